// ### core/dcw_defines.vh
// Purpose: constants for the dual counter watchdog
// Assumes: APB byte addressing of word-aligned registers, 32-bit data
// Notes: offsets are byte addresses
`ifndef DCW_DEFINES_VH
`define DCW_DEFINES_VH
`define DCW_OFF_CTRL 12'h000
`define DCW_OFF_R0LO 12'h004
`define DCW_OFF_R0HI 12'h008
`define DCW_OFF_R1LO 12'h00C
`define DCW_OFF_R1HI 12'h010
`define DCW_OFF_CNT0 12'h014
`define DCW_OFF_CNT1 12'h018
`define DCW_KEY 16'h9876
`define DCW_BIT_RUN0 0
`define DCW_BIT_RUN1 1
`define DCW_BIT_LOAD 2
`define DCW_BIT_STAT0 3
`define DCW_BIT_STAT1 4
`define DCW_CNT1_W 36
`define DCW_CNT1_LOW 4
`endif

// ### core/dcw_sync.v
// Purpose: two-stage synchroniser with rising edge pulse
// Assumes: single clock
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module dcw_sync (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Level in, edge out
  input wire din,
  output reg rise
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise <= s2_r & ~s3_r;
    end
  end
endmodule

// ### core/dcw_watchdog.v
// Purpose: two-counter watchdog with APB register access
// Assumes: clk is the counting clock; PREADY always high
// Notes: load bit edge is synchronised before it retriggers counters
`timescale 1ns/1ns
`include "dcw_defines.vh"
// Behaviour
// RQ1 - First counter is 32-bit, loads reload value, decrements each cycle to zero.
// RQ2 - Run bit starts or stops first counter; its output low when stopped, reset.
// RQ3 - First output high while running nonzero; zero start gives one high cycle.
// RQ4 - Load trigger reloads first counter and counting continues from there.
// RQ5 - Reaching zero drives first output low, sets status, raises interrupt.
// RQ6 - Status bit reads one only while running and expired.
// RQ7 - Nonzero retrigger or stopping clears first status and interrupt.
// RQ8 - First output returns high only on restart with nonzero value; code also drives it high for one cycle on a start with zero reload.
// RQ9 - First counter expires after reload plus one cycles.
// RQ10 - Second counter is 36 bits; reload fills upper 32, low four zero.
// RQ11 - Second output high at reset, stopped, or running nonzero; low on expiry.
// RQ12 - Second expiry requests processor reset.
// RQ13 - Nonzero retrigger or stopping clears second status, output high.
// RQ14 - Second counter expires after sixteen times reload plus one cycles.
// RQ15 - Load bit acts on both counters via synchronised rising edge.
// RQ16 - Reload value is low halves of low and high registers.
// RQ17 - Software changes reload registers only while counter stopped.
// RQ18 - Read-back shows live counter values, no wait; second gives upper 32.
// RQ19 - Protected writes need key 9876h in upper 16 bits.
// RQ20 - Protected registers read zero in upper 16 bits.
// RQ21 - Software writes reload, then load, then run.
// RQ22 - Expired counter holds zero; keyless writes change nothing.
module dcw_watchdog (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Watchdog outputs
  output reg firstExpiryOutN,
  output reg secondExpiryOutN,
  output reg expiryInterrupt,
  output reg cpuWatchdogResetReq
);
  reg run0_r;
  reg run1_r;
  reg loadBit_r;
  reg [15:0] r0Lo_r;
  reg [15:0] r0Hi_r;
  reg [15:0] r1Lo_r;
  reg [15:0] r1Hi_r;
  reg [31:0] cnt0_r;
  reg [35:0] cnt1_r;
  reg exp0_r;
  reg exp1_r;
  reg [31:0] rb0_r;
  reg [31:0] rb1_r;
  reg run0Dly_r;
  reg run1Dly_r;
  wire loadRise;
  wire wrEn;
  wire rdEn;
  wire keyOk;
  wire [31:0] reload0Value;
  wire [31:0] reload1Value;
  wire start0;
  wire start1;
  wire mapped;

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~penable & ~pwrite;
  // RQ19 key check
  assign keyOk = (pwdata[31:16] == `DCW_KEY);
  // RQ16 reload assembly
  assign reload0Value = {r0Hi_r, r0Lo_r};
  assign reload1Value = {r1Hi_r, r1Lo_r};
  assign start0 = run0_r & ~run0Dly_r;
  assign start1 = run1_r & ~run1Dly_r;
  assign mapped = (paddr == `DCW_OFF_CTRL) | (paddr == `DCW_OFF_R0LO) | (paddr == `DCW_OFF_R0HI) |
    (paddr == `DCW_OFF_R1LO) | (paddr == `DCW_OFF_R1HI) | (paddr == `DCW_OFF_CNT0) |
    (paddr == `DCW_OFF_CNT1);

  // RQ15 load edge sync
  dcw_sync uLoadSync (
    .clk(clk),
    .rst(rst),
    .din(loadBit_r),
    .rise(loadRise)
  );

  // Register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run0_r <= 1'b0;
      run1_r <= 1'b0;
      loadBit_r <= 1'b0;
      r0Lo_r <= 16'h0000;
      r0Hi_r <= 16'h0000;
      r1Lo_r <= 16'h0000;
      r1Hi_r <= 16'h0000;
    end else if (wrEn && keyOk) begin
      // RQ22 keyless writes ignored
      case (paddr)
        `DCW_OFF_CTRL: begin
          run0_r <= pwdata[`DCW_BIT_RUN0];
          run1_r <= pwdata[`DCW_BIT_RUN1];
          loadBit_r <= pwdata[`DCW_BIT_LOAD];
        end
        `DCW_OFF_R0LO: r0Lo_r <= pwdata[15:0];
        `DCW_OFF_R0HI: r0Hi_r <= pwdata[15:0];
        `DCW_OFF_R1LO: r1Lo_r <= pwdata[15:0];
        `DCW_OFF_R1HI: r1Hi_r <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Counters
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt0_r <= 32'h00000000;
      cnt1_r <= 36'h000000000;
      exp0_r <= 1'b0;
      exp1_r <= 1'b0;
      run0Dly_r <= 1'b0;
      run1Dly_r <= 1'b0;
      firstExpiryOutN <= 1'b0;
      secondExpiryOutN <= 1'b1;
      expiryInterrupt <= 1'b0;
      cpuWatchdogResetReq <= 1'b0;
    end else begin
      run0Dly_r <= run0_r;
      run1Dly_r <= run1_r;
      // RQ2 stop first counter
      if (!run0_r) begin
        exp0_r <= 1'b0;
        firstExpiryOutN <= 1'b0;
        expiryInterrupt <= 1'b0;
      end else if (start0 || (loadRise && reload0Value != 32'h00000000)) begin
        // RQ3 RQ4 reload and run, RQ7 RQ8 clear and go high
        cnt0_r <= reload0Value;
        exp0_r <= 1'b0;
        firstExpiryOutN <= 1'b1;
        expiryInterrupt <= 1'b0;
      end else if (loadRise) begin
        cnt0_r <= reload0Value;
      end else if (cnt0_r != 32'h00000000) begin
        // RQ1 RQ9 decrement
        cnt0_r <= cnt0_r - 32'h00000001;
      end else begin
        // RQ5 RQ22 expiry hold at zero
        exp0_r <= 1'b1;
        firstExpiryOutN <= 1'b0;
        expiryInterrupt <= 1'b1;
      end
      // RQ13 stop second counter
      if (!run1_r) begin
        exp1_r <= 1'b0;
        secondExpiryOutN <= 1'b1;
        cpuWatchdogResetReq <= 1'b0;
      end else if (start1 || (loadRise && reload1Value != 32'h00000000)) begin
        // RQ10 upper bits loaded
        cnt1_r <= {reload1Value, {`DCW_CNT1_LOW{1'b0}}};
        exp1_r <= 1'b0;
        secondExpiryOutN <= 1'b1;
        cpuWatchdogResetReq <= 1'b0;
      end else if (loadRise) begin
        cnt1_r <= {reload1Value, {`DCW_CNT1_LOW{1'b0}}};
      end else if (cnt1_r != 36'h000000000) begin
        // RQ14 sixteen-fold period
        cnt1_r <= cnt1_r - 36'h000000001;
      end else begin
        // RQ11 RQ12 expiry and reset request
        exp1_r <= 1'b1;
        secondExpiryOutN <= 1'b0;
        cpuWatchdogResetReq <= 1'b1;
      end
    end
  end

  // RQ18 read-back refresh
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rb0_r <= 32'h00000000;
      rb1_r <= 32'h00000000;
    end else begin
      rb0_r <= cnt0_r;
      rb1_r <= cnt1_r[35:4];
    end
  end

  // APB read and response
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= psel & ~penable & ~mapped;
      if (rdEn) begin
        // RQ20 upper half zero, RQ6 status gated by run
        case (paddr)
          `DCW_OFF_CTRL: prdata <= {27'h0000000, exp1_r & run1_r, exp0_r & run0_r, loadBit_r, run1_r, run0_r};
          `DCW_OFF_R0LO: prdata <= {16'h0000, r0Lo_r};
          `DCW_OFF_R0HI: prdata <= {16'h0000, r0Hi_r};
          `DCW_OFF_R1LO: prdata <= {16'h0000, r1Lo_r};
          `DCW_OFF_R1HI: prdata <= {16'h0000, r1Hi_r};
          `DCW_OFF_CNT0: prdata <= rb0_r;
          `DCW_OFF_CNT1: prdata <= rb1_r;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ### verif/dcw_watchdog_asserts.sv
// Purpose: port-level checks for the dual counter watchdog
// Assumes: APB with zero wait states, byte offsets 0x000 to 0x018
// Notes: bound onto every dcw_watchdog instance
`timescale 1ns/1ns
module dcw_watchdog_asserts (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Watchdog outputs
  input wire firstExpiryOutN,
  input wire secondExpiryOutN,
  input wire expiryInterrupt,
  input wire cpuWatchdogResetReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire wrCtrl = acc && pwrite && paddr == 12'h000 && pwdata[31:16] == 16'h9876;
  ready_always_a: assert property (pready) else $error("pready low");
  int_out_a: assert property (expiryInterrupt |-> !firstExpiryOutN) else $error("interrupt with output high");
  req_out_a: assert property (cpuWatchdogResetReq == !secondExpiryOutN) else $error("reset request mismatch");
  key_hidden_a: assert property (acc && !pwrite && paddr <= 12'h010 |-> prdata[31:16] == 16'h0000)
    else $error("key visible on read");
  addr_err_a: assert property (acc |-> pslverr == (paddr > 12'h018)) else $error("pslverr wrong");
  stop_first_a: assert property (wrCtrl && !pwdata[0] |-> ##[1:3] (!firstExpiryOutN && !expiryInterrupt))
    else $error("first counter not stopped");
  stop_second_a: assert property (wrCtrl && !pwdata[1] |-> ##[1:3] (secondExpiryOutN && !cpuWatchdogResetReq))
    else $error("second counter not stopped");
  out_rise_a: assert property ($rose(firstExpiryOutN) |-> !expiryInterrupt) else $error("restart kept interrupt");
endmodule
bind dcw_watchdog dcw_watchdog_asserts i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .firstExpiryOutN(firstExpiryOutN), .secondExpiryOutN(secondExpiryOutN),
  .expiryInterrupt(expiryInterrupt), .cpuWatchdogResetReq(cpuWatchdogResetReq));

// ### verif/tb.sv
// Purpose: self-checking bench for the dual counter watchdog
// Assumes: 25 MHz clock, APB master in this module
// Notes: random reload values kept small to keep the run short
`timescale 1ns/1ns
`include "dcw_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t: mismatch", $time); end end
module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic firstExpiryOutN, secondExpiryOutN, expiryInterrupt, cpuWatchdogResetReq;
  int n_mismatch, tests_run, n, r;
  dcw_watchdog i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .firstExpiryOutN(firstExpiryOutN),
    .secondExpiryOutN(secondExpiryOutN), .expiryInterrupt(expiryInterrupt),
    .cpuWatchdogResetReq(cpuWatchdogResetReq));
  // Edges from the edge after the start write to expiry
  function int t_exp(input int rel, input int mul);
    return mul * rel + 1;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [15:0] v);
    apb(1'b1, a, {`DCW_KEY, v});
  endtask
  // Counts edges until the chosen expiry output goes low
  task tmo(input bit sec);
    n = 0;
    do begin @(posedge clk); #1 n++; end while ((sec ? secondExpiryOutN : firstExpiryOutN) && n < 2000);
    @(posedge clk);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    void'($urandom(61));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({firstExpiryOutN, secondExpiryOutN, expiryInterrupt, cpuWatchdogResetReq}, 4'b0100)
    $display("test reset done");
    r = $urandom_range(40, 1);
    wr(`DCW_OFF_R0LO, r[15:0]); wr(`DCW_OFF_R0HI, 16'h0000); wr(`DCW_OFF_CTRL, 16'h0004);
    repeat (6) @(posedge clk);
    wr(`DCW_OFF_CTRL, 16'h0005);
    tmo(1'b0);
    `CHK(n, t_exp(r, 1))
    `CHK(expiryInterrupt, 1'b1)
    apb(1'b0, `DCW_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0000000D)
    apb(1'b1, `DCW_OFF_CTRL, 32'h00000004);
    repeat (2) @(posedge clk);
    `CHK(expiryInterrupt, 1'b1)
    wr(`DCW_OFF_CTRL, 16'h0004);
    repeat (2) @(posedge clk);
    `CHK(expiryInterrupt, 1'b0)
    $display("test counter0 done");
    r = $urandom_range(6, 1);
    wr(`DCW_OFF_R1LO, r[15:0]); wr(`DCW_OFF_R1HI, 16'h0000); wr(`DCW_OFF_CTRL, 16'h0006);
    tmo(1'b1);
    `CHK(n, t_exp(r, 16))
    `CHK(cpuWatchdogResetReq, 1'b1)
    apb(1'b0, `DCW_OFF_CNT1, 32'h0);
    `CHK(rd, 32'h0)
    wr(`DCW_OFF_CTRL, 16'h0004);
    repeat (2) @(posedge clk);
    `CHK(secondExpiryOutN, 1'b1)
    apb(1'b0, 12'h01C, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("test counter1 done");
    r = $urandom_range(40, 12);
    wr(`DCW_OFF_R0LO, r[15:0]); wr(`DCW_OFF_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    apb(1'b0, `DCW_OFF_CNT0, 32'h0);
    `CHK(rd, r - 1)
    wr(`DCW_OFF_CTRL, 16'h0005);
    // retrigger delays expiry; load edge needs three more edges to cross the synchroniser
    tmo(1'b0);
    `CHK(n, t_exp(r, 1) + 3)
    wr(`DCW_OFF_CTRL, 16'h0000);
    $display("test retrigger done");
    print_verdict;
  end
endmodule
